// File: verilog/dsr_pkg.sv
/*
 * Shared constants and carrier types for the receiver status readback block.
 * Assumes one clock domain and a word-wide AHB-Lite register port.
 */
package dsr_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [7:0] IDX_RATIO_HI   = 8'h12;
    localparam logic [7:0] IDX_RATIO_LO   = 8'h13;
    localparam logic [7:0] IDX_PC_HI      = 8'h14;
    localparam logic [7:0] IDX_PC_LO      = 8'h15;
    localparam logic [7:0] IDX_PD_HI      = 8'h16;
    localparam logic [7:0] IDX_PD_LO      = 8'h17;
    localparam logic [7:0] IDX_RX_ERR     = 8'h18;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'h19;
    localparam logic [7:0] IDX_IRQ_STAT   = 8'h1b;
    localparam logic [7:0] IDX_PRE_TYPE   = 8'h1c;

    // Byte address field that carries the index.
    localparam int         IDX_LSB        = 2;
    localparam int         IDX_MSB        = 9;

    // Receiver error flag positions.
    localparam int         BIT_VALID      = 7;
    localparam int         BIT_EMPH       = 6;
    localparam int         BIT_NONAUDIO   = 5;
    localparam int         BIT_NA_PRE     = 4;
    localparam int         BIT_CRC        = 3;
    localparam int         BIT_NO_STREAM  = 2;
    localparam int         BIT_BIPHASE    = 1;
    localparam int         BIT_LOCK       = 0;

    // Flags that latch until the error register is read.
    localparam logic [7:0] LATCH_FLAGS    = 8'h0a;

    // Reset values.
    localparam logic [7:0]  MASK_RST      = 8'h00;
    localparam logic [7:0]  STAT_RST      = 8'h00;
    localparam logic [31:0] RDATA_RST     = 32'h0000_0000;

    // Bus encodings.
    localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
    localparam logic       HRESP_OKAY     = 1'h0;

    // Receiver flags, packed in register bit order.
    typedef struct packed {
        logic received_valid_flag;
        logic emphasis;
        logic nonaudio;
        logic nonaudio_preamble;
        logic status_checksum_fault;
        logic input_absent_flag;
        logic biphase_parity_err;
        logic lock;
    } dsr_rx_t;

    // Burst preamble words and the detector state that qualifies them.
    typedef struct packed {
        logic        compressed_det;
        logic        subframe_mode;
        logic [15:0] pc_word;
        logic [15:0] pd_word;
        logic [15:0] pc_word_b;
    } dsr_burst_t;

endpackage

// File: verilog/dsr_flag_cell.sv
/*
 * One receiver error flag with its change or error event.
 * Assumes the source is already in the i_mclk domain.
 */
`timescale 1ns/1ns

module dsr_flag_cell #(
    parameter bit LATCH = 1'b0
) (
    // Clock and reset.
    input  wire logic i_mclk,
    input  wire logic i_rst_n,
    // Source and read strobe.
    input  wire logic i_src,
    input  wire logic i_rd_clr,
    // Flag and event.
    output logic      o_flag,
    output logic      o_event
);

    logic flag_reg;
    logic flag_next;

    always_comb
    begin
        if (LATCH)
        begin
            // An error in the reading cycle survives the clear.
            flag_next = i_src | (flag_reg & ~i_rd_clr);
            o_event   = i_src;
        end
        else
        begin
            // A read leaves the level alone; only a change is an event.
            flag_next = i_src;
            o_event   = i_src ^ flag_reg;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            flag_reg <= 1'b0;
        else
            flag_reg <= flag_next;
    end

    assign o_flag = flag_reg;

endmodule

// File: verilog/dsr_status_regs.sv
/*
 * Receiver and rate converter status readback registers on AHB-Lite.
 * Assumes receiver and rate converter inputs are in the i_mclk domain,
 * a single AHB-Lite master, and whole-word single transfers.
 */
// Chosen here: register access over AHB-Lite.
// Overview of operation
// - Fifteen-bit rate ratio: upper seven bits at 0x12, lower eight at 0x13.
// - Preamble C word at 0x14/0x15 only while compressed data detected, else zero.
// - Preamble D word at 0x16/0x17 only while compressed data detected, else zero.
// - In subframe nonaudio mode, 0x16/0x17 show channel B preamble C instead.
// - Error register 0x18: validity, emphasis, nonaudio, preamble, CRC, stream, biphase, lock.
// - Nonaudio preamble flag set on burst detection; type register names the preamble.
// - Nonaudio preamble flag holds after read; interrupts only on state change.
// - No-stream flag high without input; holds after read; interrupts only on change.
`timescale 1ns/1ns

module dsr_status_regs
    import dsr_pkg::*;
#(
    parameter int RATIO_W    = 15,
    parameter int PRE_TYPE_W = 4
) (
    // Clock and reset.
    input  wire logic                  i_mclk,
    input  wire logic                  i_rst_n,
    // AHB-Lite slave.
    input  wire logic                  i_hsel,
    input  wire logic [31:0]           i_haddr,
    input  wire logic [1:0]            i_htrans,
    input  wire logic                  i_hwrite,
    input  wire logic [2:0]            i_hsize,
    input  wire logic [31:0]           i_hwdata,
    input  wire logic                  i_hready,
    output logic                       o_hreadyout,
    output logic                       o_hresp,
    output logic [31:0]                o_hrdata,
    // Rate converter and receiver status.
    input  wire logic [RATIO_W-1:0]    i_rate_ratio,
    input  wire dsr_pkg::dsr_rx_t      i_rx,
    input  wire dsr_pkg::dsr_burst_t   i_burst,
    input  wire logic [PRE_TYPE_W-1:0] i_pre_type,
    // Interrupt.
    output logic                       o_irq
);

    import dsr_pkg::*;

    // The ratio fills seven plus eight bits; the type fits one byte.
    if (RATIO_W < 9 || RATIO_W > 15)
    begin : g_bad_ratio_w
        $error("RATIO_W must lie between 9 and 15.");
    end
    if (PRE_TYPE_W < 1 || PRE_TYPE_W > 8)
    begin : g_bad_type_w
        $error("PRE_TYPE_W must lie between 1 and 8.");
    end

    // Bus state.
    logic            addr_ok;
    logic            rd_take;
    logic            wr_take;
    logic [7:0]      addr_idx;
    logic            wr_pend_reg;
    logic [7:0]      wr_idx_reg;
    logic [31:0]     rdata_reg;
    logic [31:0]     rdata_next;

    // Register state.
    logic [7:0]      mask_reg;
    logic [7:0]      stat_reg;
    logic [7:0]      stat_next;
    logic [7:0]      w1c_bits;
    logic            mask_wr;

    // Flag datapath.
    logic [7:0]      rx_src;
    logic [7:0]      rx_flags;
    logic [7:0]      rx_events;
    logic            err_rd;

    // Readback views.
    logic [14:0]     ratio_full;
    logic [15:0]     pc_view;
    logic [15:0]     pd_view;
    logic [7:0]      type_view;

    // True when an index selects the given register.
    function automatic logic hit(input logic [7:0] idx,
                                 input logic [7:0] reg_idx);
        hit = (idx == reg_idx);
    endfunction

    // Address phase.

    // A transfer is taken only when the previous one has completed.
    assign addr_ok  = i_hsel & i_hready & i_htrans[1];
    assign rd_take  = addr_ok & ~i_hwrite;
    assign wr_take  = addr_ok & i_hwrite;
    assign addr_idx = i_haddr[IDX_MSB:IDX_LSB];

    // Upper address bits must be clear, or the access is unmapped.
    logic addr_in_map;
    assign addr_in_map = (i_haddr[31:IDX_MSB+1] == '0)
                       & (i_haddr[IDX_LSB-1:0] == 2'h0);

    // The slave never stalls and never signals an error.
    assign o_hreadyout = 1'b1;
    assign o_hresp     = HRESP_OKAY;

    // Receiver flags.

    assign rx_src = i_rx;

    assign err_rd = rd_take & addr_in_map & hit(addr_idx, IDX_RX_ERR);

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_flag
            dsr_flag_cell #(
                .LATCH (LATCH_FLAGS[gi])
            ) u_cell (
                .i_mclk   (i_mclk),
                .i_rst_n  (i_rst_n),
                .i_src    (rx_src[gi]),
                .i_rd_clr (err_rd),
                .o_flag   (rx_flags[gi]),
                .o_event  (rx_events[gi])
            );
        end
    endgenerate

    // Readback views.

    assign ratio_full = 15'(i_rate_ratio);

    assign pc_view = i_burst.compressed_det ? i_burst.pc_word : 16'h0000;

    always_comb
    begin
        if (!i_burst.compressed_det)
            pd_view = 16'h0000;
        else if (i_burst.subframe_mode)
            pd_view = i_burst.pc_word_b;
        else
            pd_view = i_burst.pd_word;
    end

    assign type_view = 8'(i_pre_type);

    // Read data.

    // Data are taken at the address edge, so a read of the error
    // register returns the flags as they stood before its clear.
    always_comb
    begin
        rdata_next = 32'h0000_0000;
        if (addr_in_map)
        begin
            unique case (addr_idx)
                IDX_RATIO_HI: rdata_next[6:0] = ratio_full[14:8];
                IDX_RATIO_LO: rdata_next[7:0] = ratio_full[7:0];
                IDX_PC_HI:    rdata_next[7:0] = pc_view[15:8];
                IDX_PC_LO:    rdata_next[7:0] = pc_view[7:0];
                IDX_PD_HI:    rdata_next[7:0] = pd_view[15:8];
                IDX_PD_LO:    rdata_next[7:0] = pd_view[7:0];
                IDX_RX_ERR:   rdata_next[7:0] = rx_flags;
                IDX_IRQ_MASK: rdata_next[7:0] = mask_reg;
                IDX_IRQ_STAT: rdata_next[7:0] = stat_reg;
                IDX_PRE_TYPE: rdata_next[7:0] = type_view;
                default:      rdata_next      = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            rdata_reg <= RDATA_RST;
        else if (rd_take)
            rdata_reg <= rdata_next;
    end

    assign o_hrdata = rdata_reg;

    // Write data phase.

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 8'h00;
        end
        else
        begin
            wr_pend_reg <= wr_take & addr_in_map;
            if (wr_take)
                wr_idx_reg <= addr_idx;
        end
    end

    // Only the mask and status registers take writes; the rest are
    // read-only and ignore them.
    assign mask_wr  = wr_pend_reg & hit(wr_idx_reg, IDX_IRQ_MASK);
    assign w1c_bits = (wr_pend_reg & hit(wr_idx_reg, IDX_IRQ_STAT))
                    ? i_hwdata[7:0] : 8'h00;

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            mask_reg <= MASK_RST;
        else if (mask_wr)
            mask_reg <= i_hwdata[7:0];
    end

    // Interrupt status.

    // A new event beats a write-one-to-clear in the same cycle.
    assign stat_next = (stat_reg & ~w1c_bits) | rx_events;

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            stat_reg <= STAT_RST;
        else
            stat_reg <= stat_next;
    end

    // A mask bit of one lets its status bit interrupt.
    assign o_irq = |(stat_reg & mask_reg);

endmodule

// File: verif/dsr_stream_src.sv
/* Model of the incoming stream source that feeds the receiver flags.
   Assumes the bench sets the wanted stream state just after a clock edge. */
`timescale 1ns/1ns

module dsr_stream_src
    import dsr_pkg::*;
(
    // Clock and wanted stream state.
    input  wire logic                i_mclk,
    input  wire logic                i_present,
    input  wire dsr_pkg::dsr_rx_t    i_want_rx,
    input  wire dsr_pkg::dsr_burst_t i_want_burst,
    // Receiver view of the stream.
    output dsr_pkg::dsr_rx_t         o_rx,
    output dsr_pkg::dsr_burst_t      o_burst
);
    dsr_rx_t    rx_view;
    dsr_burst_t burst_view;

    always_comb
    begin
        rx_view    = i_want_rx;
        burst_view = i_want_burst;
        if (!i_present)
        begin
            rx_view.input_absent_flag = 1'b1;
            rx_view.lock              = 1'b0;
            burst_view.compressed_det = 1'b0;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        o_rx    <= rx_view;
        o_burst <= burst_view;
    end
endmodule

// File: verif/dsr_status_sva.sv
/* Port assertions for the status readback block.
   Assumes one clock and reads of one whole word. */
`timescale 1ns/1ns

module dsr_status_sva
    import dsr_pkg::*;
#(
    parameter int RATIO_W    = 15,
    parameter int PRE_TYPE_W = 4
) (
    // Watched ports.
    input wire logic                i_mclk,
    input wire logic                i_rst_n,
    input wire logic                i_hsel,
    input wire logic [31:0]         i_haddr,
    input wire logic [1:0]          i_htrans,
    input wire logic                i_hwrite,
    input wire logic                i_hready,
    input wire logic [31:0]         o_hrdata,
    input wire logic [RATIO_W-1:0]  i_rate_ratio,
    input wire dsr_pkg::dsr_rx_t    i_rx,
    input wire dsr_pkg::dsr_burst_t i_burst,
    input wire logic                o_irq
);
    logic       take;
    logic       rd;
    logic       rde;
    logic [7:0] ix;
    assign take = i_hsel & i_hready & i_htrans[1];
    assign rd   = take & ~i_hwrite;
    assign ix   = i_haddr[9:2];
    assign rde  = rd && ix == IDX_RX_ERR;

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    a_ratio_high: assert property (rd && ix == IDX_RATIO_HI |=>
        o_hrdata == {25'h0, $past(i_rate_ratio[14:8])}) else $error("ratio high wrong");
    a_ratio_low: assert property (rd && ix == IDX_RATIO_LO |=>
        o_hrdata == {24'h0, $past(i_rate_ratio[7:0])}) else $error("ratio low wrong");
    a_pc_gated: assert property (rd && ix == IDX_PC_HI |=>
        o_hrdata == ($past(i_burst.compressed_det) ? {24'h0, $past(i_burst.pc_word[15:8])}
        : 32'h0)) else $error("preamble c gating wrong");
    a_pd_select: assert property (rd && ix == IDX_PD_LO |=>
        o_hrdata[7:0] == (!$past(i_burst.compressed_det) ? 8'h00 : $past(i_burst.subframe_mode)
        ? $past(i_burst.pc_word_b[7:0]) : $past(i_burst.pd_word[7:0])))
        else $error("preamble d select wrong");
    a_level_flags: assert property (rde && $past(i_rst_n) && $stable(i_rx) |=>
        o_hrdata[7:4] == $past(i_rx[7:4]) && o_hrdata[2] == $past(i_rx[2])
        && o_hrdata[0] == $past(i_rx[0])) else $error("level flag wrong");
    a_latch_crc: assert property (rde && $past(i_rst_n)
        && $past(i_rx.status_checksum_fault) |=> o_hrdata[BIT_CRC]) else $error("crc not held");
    a_latch_bip: assert property (rde && $past(i_rst_n)
        && $past(i_rx.biphase_parity_err) |=> o_hrdata[BIT_BIPHASE]) else $error("bip not held");
    a_read_clears: assert property (rde && !i_rx[3] && !i_rx[1]
        ##1 (!rd && !i_rx[3] && !i_rx[1]) [*2] ##1 rde |=> !o_hrdata[3] && !o_hrdata[1])
        else $error("error bits not cleared");
    a_irq_cause: assert property ($rose(o_irq) |-> $past(i_rx) != $past(i_rx, 2)
        || $past(i_rx[3]) || $past(i_rx[1]) || $past(take && i_hwrite, 2)
        || !$past(i_rst_n, 2)) else $error("irq without cause");

    cover property (rde && $past(i_rx[BIT_CRC]));
    cover property ($rose(o_irq));
    cover property (rd && ix == IDX_PD_HI && i_burst.subframe_mode);
endmodule

// File: verif/testbench.sv
/* Self-checking bench for the status readback block.
   Assumes the stream source model and the port checker beside it. */
`timescale 1ns/1ns

module testbench;
    import dsr_pkg::*;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [14:0] ratio = 15'h0;
    logic [3:0]  pre_type = 4'h0;
    logic        present = 1'b1;
    dsr_rx_t     want_rx = '0;
    dsr_burst_t  want_burst = '0;
    dsr_rx_t     rx;
    dsr_burst_t  burst;
    logic        hready;
    logic        hresp;
    logic [31:0] hrdata;
    logic        irq;
    logic [31:0] d;
    int          n_fail = 0;
    int          n_compared = 0;
    int          cyc = 0;

    always #20 clk = ~clk;

    dsr_stream_src dsr_stream_src_inst (.i_mclk(clk), .i_present(present),
        .i_want_rx(want_rx), .i_want_burst(want_burst), .o_rx(rx), .o_burst(burst));
    dsr_status_regs dsr_status_regs_inst (.i_mclk(clk), .i_rst_n(rst_n), .i_hsel(1'b1),
        .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
        .i_hwdata(hwdata), .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
        .o_hrdata(hrdata), .i_rate_ratio(ratio), .i_rx(rx), .i_burst(burst),
        .i_pre_type(pre_type), .o_irq(irq));

    task automatic results();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
        @(posedge clk);
        haddr <= {22'h0, idx, 2'h0};
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        d = hrdata;
        chk("response", 32'h0, {31'h0, hresp});
    endtask

    task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        chk(what, exp, d);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk);
    endtask

    task automatic t_ratio();
        ratio <= 15'h7abc;
        settle();
        rdc("ratio high", IDX_RATIO_HI, 32'h7a);
        rdc("ratio low", IDX_RATIO_LO, 32'hbc);
        bus(1'b1, IDX_RATIO_HI, 32'hff);
        rdc("ratio high kept", IDX_RATIO_HI, 32'h7a);
        rdc("unmapped", 8'h3f, 32'h0);
    endtask

    task automatic t_burst();
        logic [15:0] w;
        for (int m = 0; m < 3; m++)
        begin
            want_burst <= {(m != 0), (m == 2), 16'h1234, 16'h5678, 16'h9abc};
            settle();
            w = (m == 2) ? 16'h9abc : 16'h5678;
            rdc("pc high", IDX_PC_HI, m ? 32'h12 : 32'h0);
            rdc("pc low", IDX_PC_LO, m ? 32'h34 : 32'h0);
            rdc("pd high", IDX_PD_HI, m ? {24'h0, w[15:8]} : 32'h0);
            rdc("pd low", IDX_PD_LO, m ? {24'h0, w[7:0]} : 32'h0);
        end
    endtask

    task automatic t_flags();
        int         bits[5] = '{7, 6, 5, 4, 0};
        logic [7:0] v;
        for (int i = 0; i < 5; i++)
        begin
            v = 8'h1 << bits[i];
            want_rx <= v;
            pre_type <= 4'(i + 1);
            settle();
            rdc("error flags", IDX_RX_ERR, {24'h0, v});
            rdc("preamble type", IDX_PRE_TYPE, 32'(i + 1));
        end
        want_rx <= '0;
        settle();
    endtask

    task automatic t_latch();
        logic [7:0] v;
        for (int b = 1; b < 4; b += 2)
        begin
            v = 8'h1 << b;
            want_rx <= v;
            @(posedge clk);
            want_rx <= '0;
            settle();
            rdc("error latched", IDX_RX_ERR, {24'h0, v});
            rdc("error cleared", IDX_RX_ERR, 32'h0);
            want_rx <= v;
            settle();
            rdc("error during read", IDX_RX_ERR, {24'h0, v});
            want_rx <= '0;
            settle();
            rdc("error beats clear", IDX_RX_ERR, {24'h0, v});
            rdc("error cleared late", IDX_RX_ERR, 32'h0);
        end
    endtask

    task automatic t_irq();
        bus(1'b1, IDX_IRQ_STAT, 32'hff);
        bus(1'b1, IDX_IRQ_MASK, 32'h04);
        rdc("mask readback", IDX_IRQ_MASK, 32'h04);
        settle();
        chk("irq idle", 32'h0, {31'h0, irq});
        present <= 1'b0;
        settle();
        chk("irq absent", 32'h1, {31'h0, irq});
        rdc("irq status", IDX_IRQ_STAT, 32'h04);
        rdc("absent flag", IDX_RX_ERR, 32'h04);
        bus(1'b1, IDX_IRQ_STAT, 32'h04);
        settle();
        rdc("absent held", IDX_RX_ERR, 32'h04);
        chk("irq quiet", 32'h0, {31'h0, irq});
        present <= 1'b1;
        settle();
        chk("irq change", 32'h1, {31'h0, irq});
        bus(1'b1, IDX_IRQ_MASK, 32'h0);
        settle();
        chk("irq masked", 32'h0, {31'h0, irq});
    endtask

    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            n_fail++;
            results();
        end
    end

    initial
    begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_ratio();
        t_burst();
        t_flags();
        t_latch();
        t_irq();
        results();
    end
endmodule

bind dsr_status_regs dsr_status_sva #(.RATIO_W(RATIO_W), .PRE_TYPE_W(PRE_TYPE_W))
    dsr_status_sva_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_hsel(i_hsel),
    .i_haddr(i_haddr), .i_htrans(i_htrans), .i_hwrite(i_hwrite), .i_hready(i_hready),
    .o_hrdata(o_hrdata), .i_rate_ratio(i_rate_ratio), .i_rx(i_rx), .i_burst(i_burst),
    .o_irq(o_irq));
